/* File: fcsm_top.sv */
// Command-cycle state machine for read, unlock, erase and erase suspend
`timescale 1ns/1ps

// Functional notes
// RULE_01: Read protect active when lock bits 5 and 2 clear and password mismatches.
// RULE_02: Suspend before erase window opens forces poll-ready and blocks later sector queueing.
// RULE_03: Status clear command resets status register only, poll bits untouched.
// RULE_04: Chip erase, sector erase, evaluate return to read on success.
// RULE_05: Suspend request state enters erase suspended after suspend latency alone.
// RULE_06: Failed erase hangs until software reset returns it to read.
// RULE_07: Unlock AAh at 555h, 55h at 2AAh, then third cycle dispatch.
// RULE_08: Status bit 7 set only when other status bits are valid.
// RULE_09: Failure flag high reports a failed embedded operation.
// RULE_10: Erase window flag high once sector erase actually runs.
// RULE_11: Ready-busy low while chip erase, sector erase, suspend request or evaluate is active.
module fcsm_top
	import fcsm_pkg::*;
#(
	parameter int SUSP_CYC = SUSPEND_LAT_CYC,
	parameter int WIN_CYC  = ERASE_WIN_CYC,
	parameter int SER_CYC  = SECTOR_ERASE_CYC,
	parameter int CER_CYC  = CHIP_ERASE_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wr_strobe,
	input  wire fcsm_wr_s    wr_cmd,
	input  wire logic [7:0]  lock_config_reg,
	input  wire logic        password_match,
	input  wire logic        erase_fail,
	output logic             read_protect,
	output logic [7:0]       status_reg,
	output fcsm_poll_s       poll_flags,
	output logic             ready_busy_out,
	output logic             ready_busy_oe,
	output logic             prog_start,
	output logic             bufld_start,
	output logic             bypass_start,
	output logic             ident_start,
	output fcsm_state_e      state
);

	logic        rst_s1_r;
	logic        rst_s2_r;
	logic        wr_s1_r;
	logic        wr_s2_r;
	logic        wr_d_r;
	fcsm_wr_s    cmd_s1_r;
	fcsm_wr_s    cmd_s2_r;
	logic        wr_ev;
	fcsm_state_e st_r;
	fcsm_state_e st_nxt;
	logic [FCSM_CNT_W-1:0] cnt_r;
	logic [FCSM_CNT_W-1:0] cnt_nxt;
	logic [7:0]  sr_r;
	logic [7:0]  sr_nxt;
	fcsm_poll_s  pf_r;
	fcsm_poll_s  pf_nxt;
	logic        noq_r;
	logic        noq_nxt;
	logic        fail_r;
	logic        fail_nxt;
	logic        rp_r;
	logic        rp_nxt;
	logic [3:0]  disp_r;
	logic [3:0]  disp_nxt;
	logic        is_a5;
	logic        is_2a;
	logic [7:0]  d;

	// Reset release synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Strobe and command both come off the async bus; command must hold while strobe syncs
	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			wr_s1_r  <= 1'b0;
			wr_s2_r  <= 1'b0;
			wr_d_r   <= 1'b0;
			cmd_s1_r <= '0;
			cmd_s2_r <= '0;
		end else begin
			wr_s1_r  <= wr_strobe;
			wr_s2_r  <= wr_s1_r;
			wr_d_r   <= wr_s2_r;
			cmd_s1_r <= wr_cmd;
			cmd_s2_r <= cmd_s1_r;
		end
	end

	assign wr_ev = wr_s2_r & ~wr_d_r;
	assign d     = cmd_s2_r.data;
	assign is_a5 = (cmd_s2_r.addr == FCSM_ADDR_555);
	assign is_2a = (cmd_s2_r.addr == FCSM_ADDR_2AA);

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		sr_nxt   = sr_r;
		pf_nxt   = pf_r;
		noq_nxt  = noq_r;
		fail_nxt = fail_r | erase_fail;
		disp_nxt = 4'h0;
		rp_nxt   = ~lock_config_reg[FCSM_LOCK_RD_BIT] & ~lock_config_reg[FCSM_LOCK_PW_BIT]
			& ~password_match; // RULE_01
		if (wr_ev && d == FCSM_CMD_SR_CLR && (st_r == FCSM_READ || st_r == FCSM_ES)) begin
			sr_nxt = FCSM_SR_RESET; // RULE_03
		end
		unique case (st_r)
			FCSM_READ: begin
				if (wr_ev && is_a5 && d == FCSM_CMD_UNLOCK1) begin
					st_nxt = FCSM_UL1; // RULE_07
				end else if (wr_ev && d == FCSM_CMD_EVAL && !rp_r) begin
					st_nxt  = FCSM_ESS;
					cnt_nxt = FCSM_CNT_W'(EVAL_CYC);
					sr_nxt[FCSM_SR_VALID_BIT] = 1'b0;
				end
			end
			FCSM_UL1: begin
				if (wr_ev) begin
					st_nxt = (is_2a && d == FCSM_CMD_UNLOCK2) ? FCSM_UL2 : FCSM_READ; // RULE_07
				end
			end
			FCSM_UL2: begin
				if (wr_ev) begin
					st_nxt = FCSM_READ;
					if (!rp_r) begin
						unique case (d) // RULE_07
							FCSM_CMD_PROG:   disp_nxt = 4'h1;
							FCSM_CMD_BUFLD:  disp_nxt = 4'h2;
							FCSM_CMD_BYPASS: disp_nxt = 4'h4;
							FCSM_CMD_IDENT:  disp_nxt = 4'h8;
							FCSM_CMD_ERASE:  st_nxt = FCSM_ER;
							default:         st_nxt = FCSM_READ;
						endcase
					end else if (d == FCSM_CMD_IDENT) begin
						disp_nxt = 4'h8;
					end
				end
			end
			FCSM_ER: begin
				if (wr_ev) begin
					st_nxt = (is_a5 && d == FCSM_CMD_UNLOCK1) ? FCSM_ERUL1 : FCSM_READ;
				end
			end
			FCSM_ERUL1: begin
				if (wr_ev) begin
					st_nxt = (is_2a && d == FCSM_CMD_UNLOCK2) ? FCSM_ERUL2 : FCSM_READ;
				end
			end
			FCSM_ERUL2: begin
				if (wr_ev) begin
					st_nxt   = FCSM_READ;
					fail_nxt = 1'b0;
					sr_nxt[FCSM_SR_VALID_BIT] = 1'b0;
					pf_nxt   = '0;
					noq_nxt  = 1'b0;
					if (is_a5 && d == FCSM_CMD_CHIP) begin
						st_nxt  = FCSM_CER;
						cnt_nxt = FCSM_CNT_W'(CER_CYC);
					end else if (d == FCSM_CMD_SECTOR) begin
						st_nxt  = FCSM_SER;
						cnt_nxt = FCSM_CNT_W'(SER_CYC + WIN_CYC);
					end else begin
						sr_nxt[FCSM_SR_VALID_BIT] = 1'b1;
					end
				end
			end
			FCSM_CER, FCSM_SER, FCSM_ESS: begin
				if (fail_r) begin
					// Hang keeps status valid until reset
					sr_nxt[FCSM_SR_VALID_BIT] = 1'b1; // RULE_08
					sr_nxt[FCSM_SR_ERASE_BIT] = 1'b1;
					pf_nxt.failure_flag       = 1'b1; // RULE_09
					if (wr_ev && d == FCSM_CMD_RESET) begin
						st_nxt   = FCSM_READ; // RULE_06
						fail_nxt = 1'b0;
						sr_nxt   = FCSM_SR_RESET;
						pf_nxt   = '0;
					end
				end else if (cnt_r == '0) begin
					st_nxt = FCSM_READ; // RULE_04
					sr_nxt = FCSM_SR_RESET; // RULE_08
					pf_nxt = '0;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
					if (st_r == FCSM_SER && cnt_r <= FCSM_CNT_W'(SER_CYC)) begin
						pf_nxt.erase_window_flag = 1'b1; // RULE_10
					end
					if (st_r == FCSM_SER && wr_ev && d == FCSM_CMD_SUSPEND) begin
						st_nxt = FCSM_ESR;
						if (!pf_r.erase_window_flag) begin
							pf_nxt.poll_ready_flag = 1'b1; // RULE_02
							noq_nxt = 1'b1; // RULE_02
						end
					end else if (st_r == FCSM_SER && wr_ev && d == FCSM_CMD_SECTOR
						&& !pf_r.erase_window_flag && !noq_r) begin
						cnt_nxt = FCSM_CNT_W'(SER_CYC + WIN_CYC); // RULE_02
					end
				end
			end
			FCSM_ESR: begin
				// Erase count is frozen here and kept for the resume
				st_nxt = FCSM_ES; // RULE_05
				sr_nxt[FCSM_SR_SUSP_BIT]  = 1'b1;
				sr_nxt[FCSM_SR_VALID_BIT] = 1'b1;
			end
			FCSM_ES: begin
				if (wr_ev && d == FCSM_CMD_RESUME) begin
					st_nxt = FCSM_SER;
					sr_nxt[FCSM_SR_SUSP_BIT]  = 1'b0;
					sr_nxt[FCSM_SR_VALID_BIT] = 1'b0;
				end
			end
			default: st_nxt = FCSM_READ;
		endcase
	end

	// Suspend latency stretched by a small hold counter
	logic [FCSM_CNT_W-1:0] lat_r;
	logic [FCSM_CNT_W-1:0] lat_nxt;
	fcsm_state_e           st_g;

	always_comb begin
		st_g    = st_nxt;
		lat_nxt = '0;
		if (st_r == FCSM_ESR) begin
			lat_nxt = lat_r + 1'b1;
			st_g    = (lat_r >= FCSM_CNT_W'(SUSP_CYC - 1)) ? FCSM_ES : FCSM_ESR; // RULE_05
		end
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			st_r           <= FCSM_READ;
			cnt_r          <= '0;
			lat_r          <= '0;
			sr_r           <= FCSM_SR_RESET;
			pf_r           <= '0;
			noq_r          <= 1'b0;
			fail_r         <= 1'b0;
			rp_r           <= 1'b0;
			disp_r         <= 4'h0;
			ready_busy_out <= 1'b1;
			ready_busy_oe  <= 1'b0;
		end else begin
			st_r           <= st_g;
			cnt_r          <= cnt_nxt;
			lat_r          <= lat_nxt;
			sr_r           <= sr_nxt;
			pf_r           <= pf_nxt;
			noq_r          <= noq_nxt;
			fail_r         <= fail_nxt;
			rp_r           <= rp_nxt;
			disp_r         <= disp_nxt;
			// Open drain: drive low only while busy
			ready_busy_out <= 1'b0;
			ready_busy_oe  <= (st_g == FCSM_CER) || (st_g == FCSM_SER)
				|| (st_g == FCSM_ESR) || (st_g == FCSM_ESS); // RULE_11
		end
	end

	assign read_protect = rp_r;
	assign status_reg   = sr_r;
	assign poll_flags   = pf_r;
	assign prog_start   = disp_r[0];
	assign bufld_start  = disp_r[1];
	assign bypass_start = disp_r[2];
	assign ident_start  = disp_r[3];
	assign state        = st_r;

	a_busy_pin: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_11
		(st_r inside {FCSM_CER, FCSM_SER, FCSM_ESR, FCSM_ESS}) |-> ready_busy_oe)
		else $error("ready busy not driven during erase");
	a_sr_clear: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_03
		(wr_ev && d == FCSM_CMD_SR_CLR && st_r inside {FCSM_READ, FCSM_ES}) |=> $stable(pf_r))
		else $error("status clear touched poll flags");
	a_susp_lat: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_05
		(st_r == FCSM_ESR && lat_r >= FCSM_CNT_W'(SUSP_CYC - 1)) |=> st_r == FCSM_ES)
		else $error("suspend request did not settle");
	a_fail_flag: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_09
		(fail_r && st_r == FCSM_SER && !wr_ev)
		|=> pf_r.failure_flag && sr_r[FCSM_SR_VALID_BIT])
		else $error("failure not reported");
	a_erase_done: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_04
		(st_r == FCSM_CER && cnt_r == '0 && !fail_r) |=> st_r == FCSM_READ)
		else $error("erase did not return to read");
	a_rp_calc: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_01
		(lock_config_reg[FCSM_LOCK_RD_BIT]) |=> !read_protect)
		else $error("read protect set with lock bit 5");
	a_early_susp: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_02
		(st_r == FCSM_SER && !fail_r && cnt_r != '0 && wr_ev && d == FCSM_CMD_SUSPEND
		&& !pf_r.erase_window_flag) |=> pf_r.poll_ready_flag && noq_r)
		else $error("early suspend not flagged");
	a_hang_reset: assert property (@(posedge clk) disable iff (!rst_s2_r) // RULE_06
		(fail_r && st_r inside {FCSM_CER, FCSM_SER, FCSM_ESS} && wr_ev && d == FCSM_CMD_RESET)
		|=> st_r == FCSM_READ)
		else $error("reset did not leave hang");

endmodule // fcsm_top

/* File: fcsm_pkg.sv */
// Package for the flash command state machine: codes, timings, carriers
package fcsm_pkg;

	localparam logic [10:0] FCSM_ADDR_555 = 11'h555;
	localparam logic [10:0] FCSM_ADDR_2AA = 11'h2AA;

	localparam logic [7:0] FCSM_CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] FCSM_CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] FCSM_CMD_RESET   = 8'hF0;
	localparam logic [7:0] FCSM_CMD_SR_READ = 8'h70;
	localparam logic [7:0] FCSM_CMD_SR_CLR  = 8'h71;
	localparam logic [7:0] FCSM_CMD_EVAL    = 8'h35;
	localparam logic [7:0] FCSM_CMD_PROG    = 8'hA0;
	localparam logic [7:0] FCSM_CMD_BUFLD   = 8'h25;
	localparam logic [7:0] FCSM_CMD_ERASE   = 8'h80;
	localparam logic [7:0] FCSM_CMD_BYPASS  = 8'h20;
	localparam logic [7:0] FCSM_CMD_IDENT   = 8'h90;
	localparam logic [7:0] FCSM_CMD_CHIP    = 8'h10;
	localparam logic [7:0] FCSM_CMD_SECTOR  = 8'h30;
	localparam logic [7:0] FCSM_CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] FCSM_CMD_RESUME  = 8'h30;

	localparam int FCSM_LOCK_RD_BIT  = 5;
	localparam int FCSM_LOCK_PW_BIT  = 2;
	localparam int FCSM_SR_VALID_BIT = 7;
	localparam int FCSM_SR_SUSP_BIT  = 6;
	localparam int FCSM_SR_ERASE_BIT = 5;

	localparam logic [7:0] FCSM_SR_RESET = 8'h80;

	localparam int CLK_PERIOD_NS    = 100;
	localparam int SUSPEND_LAT_NS   = 20000;
	localparam int SUSPEND_LAT_CYC  = SUSPEND_LAT_NS / CLK_PERIOD_NS;
	localparam int ERASE_WIN_NS     = 50000;
	localparam int ERASE_WIN_CYC    = (ERASE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECTOR_ERASE_CYC = 10000;
	localparam int CHIP_ERASE_CYC   = 40000;
	localparam int EVAL_CYC         = 64;
	localparam int FCSM_CNT_W       = 20;

	typedef enum logic [10:0] {
		FCSM_READ  = 11'h001,
		FCSM_UL1   = 11'h002,
		FCSM_UL2   = 11'h004,
		FCSM_ER    = 11'h008,
		FCSM_ERUL1 = 11'h010,
		FCSM_ERUL2 = 11'h020,
		FCSM_CER   = 11'h040,
		FCSM_SER   = 11'h080,
		FCSM_ESR   = 11'h100,
		FCSM_ES    = 11'h200,
		FCSM_ESS   = 11'h400
	} fcsm_state_e;

	typedef struct packed {
		logic [10:0] addr;
		logic [7:0]  data;
	} fcsm_wr_s;

	typedef struct packed {
		logic poll_ready_flag;
		logic failure_flag;
		logic erase_window_flag;
	} fcsm_poll_s;

endpackage

/* File: fcsm_host_model.sv */
// Host bus model issuing command write cycles to the state machine
`timescale 1ns/1ps
module fcsm_host_model
	import fcsm_pkg::*;
(
	input  wire logic clk,
	output logic      wr_strobe,
	output fcsm_wr_s  wr_cmd
);
	initial begin
		wr_strobe = 1'b0;
		wr_cmd    = '0;
	end
	// Strobe and command held 4 clocks, then 4 clocks low
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_strobe <= 1'b1;
		wr_cmd    <= '{addr: a, data: d};
		repeat (4) @(posedge clk);
		wr_strobe <= 1'b0;
		// Released bus must not keep the old value
		wr_cmd    <= ~wr_cmd;
		repeat (4) @(posedge clk);
	endtask
	task automatic unlock();
		wr(FCSM_ADDR_555, FCSM_CMD_UNLOCK1);
		wr(FCSM_ADDR_2AA, FCSM_CMD_UNLOCK2);
	endtask
endmodule // fcsm_host_model

/* File: testbench.sv */
// Self-checking bench for the flash command state machine
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench
	import fcsm_pkg::*;
;
	// Shortened timings; window kept long so a suspend lands before it
	localparam int SUSP = 4;
	localparam int WIN  = 30;
	localparam int SECTOR_ERASE_STATE  = 80;
	localparam int CHIP_ERASE_STATE  = 120;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wr_strobe;
	fcsm_wr_s    wr_cmd;
	logic [7:0]  lock_config_reg;
	logic        password_match;
	logic        erase_fail;
	logic        read_protect;
	logic [7:0]  status_reg;
	fcsm_poll_s  poll_flags;
	fcsm_poll_s  saved;
	logic        ready_busy_out;
	logic        ready_busy_oe;
	logic [3:0]  pulses;
	fcsm_state_e state;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          seed = 85;
	int          pulse_cnt[4] = '{0, 0, 0, 0};
	int          exp_cnt[4] = '{0, 0, 0, 0};
	logic [7:0]  cmds[$];
	int          n;
	logic        exp_rp;

	always #50 clk = ~clk;

	fcsm_host_model host (.clk(clk), .wr_strobe(wr_strobe), .wr_cmd(wr_cmd));

	fcsm_top #(.SUSP_CYC(SUSP), .WIN_CYC(WIN), .SER_CYC(SECTOR_ERASE_STATE), .CER_CYC(CHIP_ERASE_STATE)) dut (
		.clk(clk), .rst_b(rst_b), .wr_strobe(wr_strobe), .wr_cmd(wr_cmd),
		.lock_config_reg(lock_config_reg), .password_match(password_match),
		.erase_fail(erase_fail), .read_protect(read_protect), .status_reg(status_reg),
		.poll_flags(poll_flags), .ready_busy_out(ready_busy_out),
		.ready_busy_oe(ready_busy_oe), .prog_start(pulses[0]), .bufld_start(pulses[1]),
		.bypass_start(pulses[2]), .ident_start(pulses[3]), .state(state));

	always @(posedge clk) begin
		cycles++;
		foreach (pulse_cnt[k]) pulse_cnt[k] += int'(pulses[k] === 1'b1);
		if (cycles == 6000) begin
			failures++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wait_st(input fcsm_state_e s, input int lim);
		@(negedge clk);
		for (n = 0; n < lim && state !== s; n++) @(negedge clk);
		`CHK("state", s, state)
	endtask

	task automatic erase(input logic [7:0] c);
		host.unlock();
		host.wr(FCSM_ADDR_555, FCSM_CMD_ERASE);
		host.unlock();
		host.wr(FCSM_ADDR_555, c);
		@(negedge clk);
	endtask

	initial begin
		lock_config_reg = 8'h00;
		password_match = 1'b0;
		erase_fail = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(negedge clk);
		`CHK("status_reg", FCSM_SR_RESET, status_reg)
		`CHK("ready_busy_oe", 1'b0, ready_busy_oe)
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			lock_config_reg <= 8'($random(seed));
			password_match <= 1'($random(seed));
			repeat (4) @(negedge clk);
			exp_rp = !lock_config_reg[FCSM_LOCK_RD_BIT] && !lock_config_reg[FCSM_LOCK_PW_BIT]
				&& !password_match;
			`CHK("read_protect", exp_rp, read_protect)
		end
		// First pass protected: only the identification dispatch expected
		cmds = '{FCSM_CMD_PROG, FCSM_CMD_BUFLD, FCSM_CMD_BYPASS, FCSM_CMD_IDENT};
		for (int p = 0; p < 2; p++) begin
			@(posedge clk);
			lock_config_reg <= p ? 8'h24 : 8'h00;
			password_match <= 1'b0;
			foreach (cmds[k]) begin
				host.unlock();
				host.wr(FCSM_ADDR_555, cmds[k]);
				// Identification entry stays open under read protect
				exp_cnt[k] += (p != 0 || k == 3) ? 1 : 0;
				`CHK("start pulses", exp_cnt[k], pulse_cnt[k])
				host.wr(FCSM_ADDR_555, FCSM_CMD_RESET);
				wait_st(FCSM_READ, 4);
			end
		end
		erase(FCSM_CMD_SECTOR);
		`CHK("state", FCSM_SER, state)
		`CHK("erase_window_flag", 1'b0, poll_flags.erase_window_flag)
		`CHK("ready_busy_oe", 1'b1, ready_busy_oe)
		`CHK("ready_busy_out", 1'b0, ready_busy_out)
		for (n = 0; n < WIN + 4 && poll_flags.erase_window_flag !== 1'b1; n++) @(negedge clk);
		`CHK("erase_window_flag", 1'b1, poll_flags.erase_window_flag)
		wait_st(FCSM_READ, SECTOR_ERASE_STATE + 4);
		`CHK("ready_busy_oe", 1'b0, ready_busy_oe)
		erase(FCSM_CMD_CHIP);
		`CHK("state", FCSM_CER, state)
		wait_st(FCSM_READ, CHIP_ERASE_STATE);
		host.wr(FCSM_ADDR_555, FCSM_CMD_EVAL);
		@(negedge clk);
		`CHK("state", FCSM_ESS, state)
		wait_st(FCSM_READ, EVAL_CYC + 4);
		// Suspend before the window opens
		erase(FCSM_CMD_SECTOR);
		host.wr(FCSM_ADDR_555, FCSM_CMD_SUSPEND);
		wait_st(FCSM_ES, SUSP);
		`CHK("poll_ready_flag", 1'b1, poll_flags.poll_ready_flag)
		`CHK("ready_busy_oe", 1'b0, ready_busy_oe)
		// Status clear while suspended must spare the raised poll flags
		saved = poll_flags;
		host.wr(FCSM_ADDR_555, FCSM_CMD_SR_CLR);
		@(negedge clk);
		`CHK("status_reg", FCSM_SR_RESET, status_reg)
		`CHK("poll_flags", saved, poll_flags)
		host.wr(FCSM_ADDR_555, FCSM_CMD_RESUME);
		// Sector queued after resume is refused; a restart would overrun this limit
		host.wr(FCSM_ADDR_555, FCSM_CMD_SECTOR);
		wait_st(FCSM_READ, SECTOR_ERASE_STATE + 16);
		// Failed erase hangs until software reset
		erase(FCSM_CMD_SECTOR);
		@(posedge clk);
		erase_fail <= 1'b1;
		for (n = 0; n < 20 && poll_flags.failure_flag !== 1'b1; n++) @(negedge clk);
		`CHK("failure_flag", 1'b1, poll_flags.failure_flag)
		`CHK("status valid", 1'b1, status_reg[FCSM_SR_VALID_BIT])
		`CHK("status erase", 1'b1, status_reg[FCSM_SR_ERASE_BIT])
		repeat (SECTOR_ERASE_STATE + 10) @(negedge clk);
		`CHK("state", FCSM_SER, state)
		@(posedge clk);
		erase_fail <= 1'b0;
		host.wr(FCSM_ADDR_555, FCSM_CMD_RESET);
		wait_st(FCSM_READ, 4);
		saved = poll_flags;
		host.wr(FCSM_ADDR_555, FCSM_CMD_SR_CLR);
		@(negedge clk);
		`CHK("status_reg", FCSM_SR_RESET, status_reg)
		`CHK("poll_flags", saved, poll_flags)
		complete_run();
	end
endmodule // testbench
